// [hw/eom_defs.svh]
`ifndef EOM_DEFS_SVH
`define EOM_DEFS_SVH

`define OFS_RECOVERY_RST 8'h0a
`define OFS_MON_CTRL    8'h11
`define OFS_TAP1        8'h12
`define OFS_TAP_ENABLE  8'h15
`define OFS_DRV_CTRL    8'h18
`define OFS_OUT_EQ      8'h1e
`define OFS_TAPS23      8'h20
`define OFS_TAPS45      8'h21
`define OFS_SCAN_OV     8'h22
`define OFS_TAP_OV      8'h23
`define OFS_SCAN_CTRL   8'h24
`define OFS_CNT_UPPER   8'h25
`define OFS_CNT_LOWER   8'h26
`define OFS_ACC_INT     8'h2a
`define OFS_RATE        8'h2f
`define OFS_ADAPT_MODE  8'h31
`define OFS_LOCK_VAL    8'h3e
`define OFS_TAP_OBS1    8'h71

`define RST_MON_CTRL    8'h20
`define RST_TAP_OV      8'h40
`define RST_LOCK_VAL    8'h80
`define RST_ZERO        8'h00

`define BIT_LOCK_CHECK  7
`define BIT_SCAN_EN     7
`define BIT_SCAN_START  0
`define BIT_DFE_TRIG    2
`define BIT_MON_PWR     5
`define BIT_TAP_MANUAL  7
`define BIT_TAP_OV      6
`define BIT_EQ_PD       3
`define BIT_SLOW_EDGE   2
`define BIT_LEQ_TRIG    0
`define BIT_TAP1_POL    7

`define ACC_SHIFT       4
`define FIFO_WIDTH      16
`define FIFO_DEPTH      8
`define OFFSET_LAST     12'hfff

`endif

// [hw/eom_pkg.sv]
package eom_pkg;
    typedef struct packed {
        logic pol1;
        logic [4:0] w1;
        logic [3:0] pol;
        logic [3:0] w2;
        logic [3:0] w3;
        logic [3:0] w4;
        logic [3:0] w5;
    } tap_set_t;

    typedef struct packed {
        logic [5:0] phase;
        logic [5:0] voltage;
    } scan_offset_t;

    typedef enum logic [1:0] {
        scan_idle,
        scan_accum,
        scan_push
    } scan_state_t;
endpackage

// [hw/eye_monitor_readout.sv]
`include "eom_defs.svh"

module count_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] fill;
    logic push;
    logic pop;

    assign in_ready = (fill != DEPTH[AW:0]);
    assign out_valid = (fill != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            fill <= fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

module eye_monitor_readout
    import eom_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    // Register port from the SMBus engine
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Analog and recovery status, asynchronous
    input wire logic error_hit,
    input wire logic clock_data_recovery_locked,
    input wire logic signal_detect,
    input wire logic clock_data_recovery_request,
    // Adaptation engine results, same clock
    input wire logic dfe_adapt_done,
    input wire logic dfe_adapt_better,
    input wire tap_set_t dfe_adapt_taps,
    // Monitor control
    output logic monitor_power,
    output logic [1:0] voltage_range,
    output scan_offset_t scan_offset,
    output logic lock_check_enable,
    output logic scan_override,
    // Equalizer control
    output tap_set_t applied_taps,
    output logic manual_taps_active,
    output logic dfe_adapt_start,
    output logic linear_equalizer_adapt_start,
    output logic [1:0] adapt_mode,
    output logic slow_edge
);
    logic [7:0] r0a, r11, r12, r15, r18, r1e, r20, r21, r22, r23, r24, r2a, r2f, r31, r3e;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic err_s, lock_s, sig_s, mon_req_s;
    logic lock_d, sig_d, manual_touched;
    scan_state_t scan_state;
    logic [15:0] acc_cnt, err_cnt;
    logic [15:0] acc_limit;
    logic [11:0] offset;
    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [15:0] fifo_out_data;
    logic [15:0] shown;
    logic upper_done, lower_done;
    logic wr_scan, scan_stop, recovery_reset, next_dfe_start, next_leq_start;
    tap_set_t reg_taps;

    function automatic logic hit(input logic [7:0] ofs);
        hit = (reg_addr == ofs);
    endfunction
    // Two-stage synchronisers for the asynchronous status inputs
    generate
        for (genvar i = 0; i < 4; i++) begin : g_sync
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    sync1[i] <= 1'b0;
                    sync2[i] <= 1'b0;
                end else begin
                    sync1[i] <= (i == 0) ? error_hit : (i == 1) ? clock_data_recovery_locked :
                                (i == 2) ? signal_detect : clock_data_recovery_request;
                    sync2[i] <= sync1[i];
                end
            end
        end
    endgenerate
    assign err_s = sync2[0];
    assign lock_s = sync2[1];
    assign sig_s = sync2[2];
    assign mon_req_s = sync2[3];
    assign wr_scan = reg_wr && hit(`OFS_SCAN_CTRL);
    assign scan_stop = wr_scan && !reg_wdata[`BIT_SCAN_EN];
    assign reg_taps = '{pol1: r12[`BIT_TAP1_POL], w1: r12[4:0], pol: r11[3:0],
                        w2: r20[3:0], w3: r20[7:4], w4: r21[3:0], w5: r21[7:4]};

    // Read/write registers, tap fields also loaded from a better adaptation result
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r11 <= `RST_MON_CTRL;
            r12 <= `RST_ZERO;
            r15 <= `RST_ZERO;
            r18 <= `RST_ZERO;
            r1e <= `RST_ZERO;
            r20 <= `RST_ZERO;
            r21 <= `RST_ZERO;
            r22 <= `RST_ZERO;
            r23 <= `RST_TAP_OV;
            r2a <= `RST_ZERO;
            r2f <= `RST_ZERO;
            r31 <= `RST_ZERO;
            r3e <= `RST_LOCK_VAL;
        end else begin
            if (reg_wr) begin
                if (hit(`OFS_MON_CTRL)) begin
                    r11 <= reg_wdata;
                end else if (hit(`OFS_TAP1)) begin
                    r12 <= reg_wdata;
                end else if (hit(`OFS_TAP_ENABLE)) begin
                    r15 <= reg_wdata;
                end else if (hit(`OFS_DRV_CTRL)) begin
                    r18 <= reg_wdata;
                end else if (hit(`OFS_OUT_EQ)) begin
                    r1e <= reg_wdata;
                end else if (hit(`OFS_TAPS23)) begin
                    r20 <= reg_wdata;
                end else if (hit(`OFS_TAPS45)) begin
                    r21 <= reg_wdata;
                end else if (hit(`OFS_SCAN_OV)) begin
                    r22 <= reg_wdata;
                end else if (hit(`OFS_TAP_OV)) begin
                    r23 <= reg_wdata;
                end else if (hit(`OFS_ACC_INT)) begin
                    r2a <= reg_wdata;
                end else if (hit(`OFS_RATE)) begin
                    r2f <= reg_wdata;
                end else if (hit(`OFS_ADAPT_MODE)) begin
                    r31 <= reg_wdata;
                end else if (hit(`OFS_LOCK_VAL)) begin
                    r3e <= reg_wdata;
                end
            end else if (dfe_adapt_done && dfe_adapt_better) begin
                // Only a better result replaces the starting taps
                r12 <= {dfe_adapt_taps.pol1, 2'b00, dfe_adapt_taps.w1};
                r11 <= {r11[7:4], dfe_adapt_taps.pol};
                r20 <= {dfe_adapt_taps.w3, dfe_adapt_taps.w2};
                r21 <= {dfe_adapt_taps.w5, dfe_adapt_taps.w4};
            end
        end
    end
    // Recovery reset request register, bits 3:2 act as a write pulse
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r0a <= `RST_ZERO;
        end else if (reg_wr && hit(`OFS_RECOVERY_RST)) begin
            r0a <= reg_wdata;
        end
    end
    assign recovery_reset = (reg_wr && hit(`OFS_RECOVERY_RST) && (reg_wdata[3:2] != 2'b00))
                            || (sig_s && !sig_d && !lock_s);
    // Scan control: start bit self-clears once acquisition begins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r24 <= `RST_ZERO;
        end else if (wr_scan) begin
            r24 <= reg_wdata;
        end else begin
            if (r24[`BIT_SCAN_EN] && r24[`BIT_SCAN_START]) begin
                r24[`BIT_SCAN_START] <= 1'b0;
            end
            r24[`BIT_DFE_TRIG] <= 1'b0;
        end
    end
    // Scan engine: accumulate errors per offset, push, step
    assign acc_limit = ({8'h00, r2a} + 16'h0001) << `ACC_SHIFT;

    always_ff @(posedge clk) begin
        if (sys_rst || scan_stop || !r24[`BIT_SCAN_EN]) begin
            scan_state <= scan_idle;
            acc_cnt <= '0;
            err_cnt <= '0;
            offset <= '0;
        end else begin
            case (scan_state)
                scan_idle: begin
                    if (r24[`BIT_SCAN_START]) begin
                        scan_state <= scan_accum;
                        acc_cnt <= '0;
                        err_cnt <= '0;
                    end
                end
                scan_accum: begin
                    acc_cnt <= acc_cnt + 16'h0001;
                    if (err_s && err_cnt != 16'hffff) begin
                        err_cnt <= err_cnt + 16'h0001;
                    end
                    if (acc_cnt + 16'h0001 >= acc_limit) begin
                        scan_state <= scan_push;
                    end
                end
                scan_push: begin
                    if (fifo_in_ready) begin
                        // Step to the next offset and restart the count
                        offset <= (offset == `OFFSET_LAST) ? '0 : offset + 12'h001;
                        acc_cnt <= '0;
                        err_cnt <= '0;
                        scan_state <= scan_accum;
                    end
                end
                default: scan_state <= scan_idle;
            endcase
        end
    end
    count_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .flush(scan_stop || !r24[`BIT_SCAN_EN]),
        .in_valid(scan_state == scan_push),
        .in_ready(fifo_in_ready),
        .in_data(err_cnt),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // Readout: a new count is taken only after both halves were read
    assign fifo_pop = fifo_out_valid && upper_done && lower_done;
    always_ff @(posedge clk) begin
        if (sys_rst || scan_stop) begin
            shown <= '0;
            upper_done <= 1'b1;
            lower_done <= 1'b1;
        end else if (fifo_pop) begin
            shown <= fifo_out_data;
            upper_done <= reg_rd && hit(`OFS_CNT_UPPER);
            lower_done <= 1'b0;
        end else if (reg_rd) begin
            if (hit(`OFS_CNT_UPPER)) begin
                // Upper read leaves the lower byte in the upper register
                if (!upper_done) begin
                    upper_done <= 1'b1;
                end else begin
                    lower_done <= 1'b1;
                end
            end else if (hit(`OFS_CNT_LOWER) && upper_done) begin
                lower_done <= 1'b1;
            end
        end
    end
    // Read data, unmapped offsets read as zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (hit(`OFS_CNT_UPPER)) begin
                reg_rdata <= fifo_pop ? fifo_out_data[15:8]
                             : upper_done ? shown[7:0] : shown[15:8];
            end else if (hit(`OFS_CNT_LOWER)) begin
                reg_rdata <= shown[7:0];
            end else if (hit(`OFS_RECOVERY_RST)) begin
                reg_rdata <= r0a;
            end else if (hit(`OFS_MON_CTRL)) begin
                reg_rdata <= r11;
            end else if (hit(`OFS_TAP1)) begin
                reg_rdata <= r12;
            end else if (hit(`OFS_TAP_ENABLE)) begin
                reg_rdata <= r15;
            end else if (hit(`OFS_DRV_CTRL)) begin
                reg_rdata <= r18;
            end else if (hit(`OFS_OUT_EQ)) begin
                reg_rdata <= r1e;
            end else if (hit(`OFS_TAPS23)) begin
                reg_rdata <= r20;
            end else if (hit(`OFS_TAPS45)) begin
                reg_rdata <= r21;
            end else if (hit(`OFS_SCAN_OV)) begin
                reg_rdata <= r22;
            end else if (hit(`OFS_TAP_OV)) begin
                reg_rdata <= r23;
            end else if (hit(`OFS_SCAN_CTRL)) begin
                reg_rdata <= r24;
            end else if (hit(`OFS_ACC_INT)) begin
                reg_rdata <= r2a;
            end else if (hit(`OFS_RATE)) begin
                reg_rdata <= r2f;
            end else if (hit(`OFS_ADAPT_MODE)) begin
                reg_rdata <= r31;
            end else if (hit(`OFS_LOCK_VAL)) begin
                reg_rdata <= r3e;
            end else if (hit(`OFS_TAP_OBS1)) begin
                reg_rdata <= {applied_taps.pol1, 2'b00, applied_taps.w1};
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end
    // Adaptation triggers
    always_comb begin
        next_dfe_start = 1'b0;
        next_leq_start = 1'b0;
        if (recovery_reset && r31[6:5] >= 2'd2) begin
            next_dfe_start = 1'b1;
        end
        if (wr_scan && reg_wdata[`BIT_DFE_TRIG]) begin
            next_dfe_start = 1'b1;
        end
        if (reg_wr && hit(`OFS_RATE) && r2f[`BIT_LEQ_TRIG] && !reg_wdata[`BIT_LEQ_TRIG]) begin
            next_leq_start = 1'b1;
        end
        if (manual_touched && lock_d && !lock_s) begin
            next_leq_start = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lock_d <= 1'b0;
            sig_d <= 1'b0;
            manual_touched <= 1'b0;
        end else begin
            lock_d <= lock_s;
            sig_d <= sig_s;
            if (reg_wr && manual_taps_active &&
                (hit(`OFS_TAP1) || hit(`OFS_TAPS23) || hit(`OFS_TAPS45) || hit(`OFS_MON_CTRL))) begin
                manual_touched <= 1'b1;
            end else if (lock_d && !lock_s) begin
                manual_touched <= 1'b0;
            end
        end
    end
    // Registered outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            monitor_power <= 1'b0;
            voltage_range <= 2'b00;
            scan_offset <= '0;
            lock_check_enable <= 1'b1;
            scan_override <= 1'b0;
            applied_taps <= '0;
            manual_taps_active <= 1'b0;
            dfe_adapt_start <= 1'b0;
            linear_equalizer_adapt_start <= 1'b0;
            adapt_mode <= 2'b00;
            slow_edge <= 1'b0;
        end else begin
            monitor_power <= !r11[`BIT_MON_PWR] || mon_req_s;
            voltage_range <= r11[7:6];
            scan_offset <= '{phase: offset[11:6], voltage: offset[5:0]};
            lock_check_enable <= r3e[`BIT_LOCK_CHECK];
            scan_override <= r22[7];
            manual_taps_active <= r23[`BIT_TAP_OV] && !r1e[`BIT_EQ_PD]
                                  && r15[`BIT_TAP_MANUAL];
            applied_taps <= reg_taps;
            dfe_adapt_start <= next_dfe_start;
            linear_equalizer_adapt_start <= next_leq_start;
            adapt_mode <= r31[6:5];
            slow_edge <= r18[`BIT_SLOW_EDGE];
        end
    end
endmodule

// [sim/smbus_ctrl_model.sv]
module smbus_ctrl_model (
    // Clock
    input wire logic clk,
    // Register port towards the block
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {reg_wr, reg_rd} = 2'b00;
        {reg_addr, reg_wdata} = 16'h0000;
    end

    // Idle lines show inverted values so a stale address is never reused
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #2;
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge clk) #2;
        {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk) #2;
        {reg_rd, reg_addr} = {1'b1, a};
        @(posedge clk) #2;
        {reg_rd, reg_addr} = {1'b0, ~a};
    endtask
endmodule

// [sim/eye_monitor_props.sv]
module eye_monitor_props import eom_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    // Adaptation results
    input wire logic dfe_adapt_done,
    input wire logic dfe_adapt_better,
    input wire tap_set_t dfe_adapt_taps,
    // Controls
    input wire logic monitor_power,
    input wire logic [1:0] voltage_range,
    input wire scan_offset_t scan_offset,
    input wire logic lock_check_enable,
    input wire tap_set_t applied_taps,
    input wire logic dfe_adapt_start,
    input wire logic linear_equalizer_adapt_start,
    input wire logic [1:0] adapt_mode,
    input wire logic slow_edge
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_lock_check_write: assert property (
        reg_wr && reg_addr == 8'h3e |-> ##2 lock_check_enable == $past(reg_wdata[7], 2))
        else $error("lock check enable does not follow its write");
    a_slow_edge_write: assert property (
        reg_wr && reg_addr == 8'h18 |-> ##2 slow_edge == $past(reg_wdata[2], 2))
        else $error("slow edge does not follow its write");
    a_range_code_write: assert property (
        reg_wr && reg_addr == 8'h11 |-> ##2 voltage_range == $past(reg_wdata[7:6], 2))
        else $error("voltage range does not follow its write");
    a_tap_one_write: assert property (
        reg_wr && reg_addr == 8'h12
        |-> ##2 {applied_taps.pol1, applied_taps.w1} == $past({reg_wdata[7], reg_wdata[4:0]}, 2))
        else $error("tap one does not follow its write");
    a_power_force_on: assert property (
        reg_wr && reg_addr == 8'h11 && !reg_wdata[5] |-> ##2 monitor_power)
        else $error("monitor not powered after override");
    a_lin_eq_pair: assert property (
        (reg_wr && reg_addr == 8'h2f && reg_wdata[0]) ##2 (reg_wr && reg_addr == 8'h2f && !reg_wdata[0])
        |-> ##[1:3] linear_equalizer_adapt_start)
        else $error("no linear equalizer adaptation after set and clear");
    a_dfe_reset_trig: assert property (
        reg_wr && reg_addr == 8'h0a && reg_wdata[3:2] != 2'b00 && adapt_mode[1]
        |-> ##[1:4] dfe_adapt_start)
        else $error("no feedback adaptation after recovery reset");
    a_scan_exit_idle: assert property (
        reg_wr && reg_addr == 8'h24 && !reg_wdata[7] |-> ##[1:3] scan_offset == 12'h000)
        else $error("scan offset not cleared on scan exit");
    a_offset_step_one: assert property (
        $changed(scan_offset) |-> scan_offset == $past(scan_offset) + 12'h001 || scan_offset == 12'h000)
        else $error("scan offset skipped a setting");
    a_adapt_taps_load: assert property (
        dfe_adapt_done && dfe_adapt_better && !reg_wr ##1 !reg_wr
        |-> ##1 applied_taps == $past(dfe_adapt_taps, 2))
        else $error("better adapted taps not taken");

    c_scan_step: cover property ($changed(scan_offset));
    c_dfe_start: cover property (dfe_adapt_start);
    c_lin_eq_start: cover property (linear_equalizer_adapt_start);
endmodule

bind eye_monitor_readout eye_monitor_props chk (.clk, .sys_rst, .reg_wr, .reg_addr, .reg_wdata,
    .dfe_adapt_done, .dfe_adapt_better, .dfe_adapt_taps, .monitor_power, .voltage_range,
    .scan_offset, .lock_check_enable, .applied_taps, .dfe_adapt_start,
    .linear_equalizer_adapt_start,
    .adapt_mode, .slow_edge);

// [sim/eye_monitor_readout_and_eq_override_tb_top.sv]
module eye_monitor_readout_and_eq_override_tb_top import eom_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, reg_wr, reg_rd, error_hit, clock_data_recovery_locked, signal_detect;
    logic clock_data_recovery_request, dfe_adapt_done, dfe_adapt_better, monitor_power;
    logic lock_check_enable, scan_override, manual_taps_active, dfe_adapt_start;
    logic linear_equalizer_adapt_start, slow_edge;
    logic rd_q = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, t1, t20, t21, t11;
    logic [1:0] voltage_range, adapt_mode;
    logic [8:0] note;
    logic [8:0] exp_q[$];
    logic [7:0] ra[6] = '{8'h11, 8'h23, 8'h3e, 8'h18, 8'h24, 8'h55};
    logic [7:0] rv[6] = '{8'h20, 8'h40, 8'h80, 8'h00, 8'h00, 8'h00};
    scan_offset_t scan_offset;
    tap_set_t dfe_adapt_taps, applied_taps, e;
    int err_count, checked, cyc, dfe_n, leq_n, n0;

    eye_monitor_readout uut (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .error_hit, .clock_data_recovery_locked, .signal_detect,
        .clock_data_recovery_request, .dfe_adapt_done, .dfe_adapt_better, .dfe_adapt_taps,
        .monitor_power, .voltage_range, .scan_offset, .lock_check_enable, .scan_override,
        .applied_taps, .manual_taps_active, .dfe_adapt_start, .linear_equalizer_adapt_start,
        .adapt_mode, .slow_edge);
    smbus_ctrl_model pm (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);

    task automatic check(input string n, input logic [31:0] ex, input logic [31:0] got);
        checked++;
        if (got !== ex) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", n, ex, got);
        end
    endtask

    task automatic rd_exp(input logic [7:0] a, input logic keep, input logic [7:0] ex);
        exp_q.push_back({keep, ex});
        pm.rd(a);
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        #2;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always #12.5 clk = ~clk;

    always @(posedge clk) begin
        rd_q <= reg_rd;
        cyc <= cyc + 1;
        dfe_n <= dfe_n + int'(dfe_adapt_start === 1'b1);
        leq_n <= leq_n + int'(linear_equalizer_adapt_start === 1'b1);
    end

    always @(posedge clk) begin
        if (cyc == 6000) begin
            err_count++;
            conclude();
        end
    end

    // Read results appear one cycle after the request
    always @(negedge clk) begin
        if (rd_q) begin
            note = exp_q.pop_front();
            if (note[8])
                check("reg_rdata", note[7:0], reg_rdata);
        end
    end

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        {error_hit, clock_data_recovery_locked, signal_detect, clock_data_recovery_request} = 4'h0;
        {dfe_adapt_done, dfe_adapt_better} = 2'b00;
        dfe_adapt_taps = '0;
        void'($urandom(32'h42b7));
        repeat (8) @(posedge clk);
        #2 sys_rst = 1'b0;
        foreach (ra[i]) rd_exp(ra[i], 1'b1, rv[i]);
        check("lock_check_enable", 1, lock_check_enable);
        check("monitor_power", 0, monitor_power);
        $display("reset test done");
        for (int i = 0; i < 3; i++) begin
            {t1, t20, t21, t11} = $urandom;
            pm.wr(8'h12, t1);
            pm.wr(8'h20, t20);
            pm.wr(8'h21, t21);
            pm.wr(8'h11, t11);
            pm.wr(8'h18, t11);
            settle();
            e = {t1[7], t1[4:0], t11[3:0], t20[3:0], t20[7:4], t21[3:0], t21[7:4]};
            check("applied_taps", e, applied_taps);
            check("voltage_range", t11[7:6], voltage_range);
            check("monitor_power", !t11[5], monitor_power);
            check("slow_edge", t11[2], slow_edge);
            rd_exp(8'h12, 1'b1, t1);
        end
        pm.wr(8'h11, 8'h20);
        clock_data_recovery_request = 1'b1;
        settle();
        check("monitor_power", 1, monitor_power);
        clock_data_recovery_request = 1'b0;
        for (int i = 0; i < 8; i++) begin
            pm.wr(8'h23, {1'b0, i[0], 6'h00});
            pm.wr(8'h1e, {4'h0, i[1], 3'h0});
            pm.wr(8'h15, {i[2], 7'h00});
            settle();
            check("manual_taps_active", i[0] & !i[1] & i[2], manual_taps_active);
        end
        $display("register test done");
        pm.wr(8'h3e, 8'h00);
        pm.wr(8'h22, 8'h80);
        settle();
        check("scan_override", 1, scan_override);
        pm.wr(8'h22, 8'h00);
        pm.wr(8'h2a, 8'h01);
        error_hit = 1'b1;
        pm.wr(8'h24, 8'h81);
        settle();
        rd_exp(8'h24, 1'b1, 8'h80);
        check("scan_override", 0, scan_override);
        repeat (300) @(posedge clk);
        // First four bytes dropped, then upper/lower pairs of 32 counted errors
        for (int i = 0; i < 10; i++) begin
            rd_exp(i == 7 ? 8'h26 : 8'h25, i > 3, i[0] ? 8'h20 : 8'h00);
        end
        pm.wr(8'h24, 8'h00);
        settle();
        check("scan_offset", 0, scan_offset);
        pm.wr(8'h3e, 8'h80);
        settle();
        check("lock_check_enable", 1, lock_check_enable);
        error_hit = 1'b0;
        $display("scan test done");
        n0 = leq_n;
        pm.wr(8'h2f, 8'h01);
        pm.wr(8'h2f, 8'h00);
        settle();
        check("linear_equalizer_adapt_start", n0 + 1, leq_n);
        // Manual taps active, then lock is lost after a tap write
        pm.wr(8'h1e, 8'h00);
        clock_data_recovery_locked = 1'b1;
        settle();
        pm.wr(8'h12, t1);
        clock_data_recovery_locked = 1'b0;
        settle();
        settle();
        check("linear_equalizer_adapt_start", n0 + 2, leq_n);
        rd_exp(8'h71, 1'b1, {t1[7], 2'b00, t1[4:0]});
        pm.wr(8'h12, t1);
        n0 = dfe_n;
        pm.wr(8'h24, 8'h04);
        pm.wr(8'h31, 8'h40);
        pm.wr(8'h0a, 8'h04);
        settle();
        signal_detect = 1'b1;
        settle();
        check("dfe_adapt_start", n0 + 3, dfe_n);
        check("adapt_mode", 2'b10, adapt_mode);
        pm.wr(8'h31, 8'h00);
        pm.wr(8'h0a, 8'h08);
        settle();
        check("dfe_adapt_start", n0 + 3, dfe_n);
        e = {t1[7], t1[4:0], 4'h0, t20[3:0], t20[7:4], t21[3:0], t21[7:4]};
        for (int i = 0; i < 2; i++) begin
            dfe_adapt_taps = 26'($urandom);
            dfe_adapt_better = i[0];
            dfe_adapt_done = 1'b1;
            @(posedge clk);
            #2 dfe_adapt_done = 1'b0;
            settle();
            if (i == 1)
                e = dfe_adapt_taps;
            check("applied_taps", e, applied_taps);
        end
        $display("adaptation test done");
        conclude();
    end
endmodule
